// ### src/crbs_pkg.sv
package crbs_pkg;

  // ==========================================================================
  // register map (byte offsets on the 8-bit register port)
  localparam logic [7:0] CRBS_OFF_B0_CTRL   = 8'h00;
  localparam logic [7:0] CRBS_OFF_OP_MODE   = 8'h01;
  localparam logic [7:0] CRBS_OFF_DIR_SEL   = 8'h02;
  localparam logic [7:0] CRBS_OFF_IRQ_STAT  = 8'h03;
  localparam logic [7:0] CRBS_OFF_IRQ_MASK  = 8'h04;
  localparam logic [7:0] CRBS_OFF_LEN_BASE  = 8'h10;

  // ==========================================================================
  // buffer 0 control fields
  localparam int CRBS_B0_FULL_BIT      = 7;
  localparam int CRBS_B0_MODE_HI_BIT   = 6;
  localparam int CRBS_B0_MODE_LO_BIT   = 5;
  localparam int CRBS_B0_REM_LEG_BIT   = 3;
  localparam int CRBS_B0_OVF_EN_BIT    = 2;
  localparam int CRBS_B0_JUMP_TABLE_OFFSET_BIT     = 1;
  localparam int CRBS_B0_REM_ENH_BIT   = 5;
  localparam int CRBS_FILTER_IDX_W     = 5;

  // ==========================================================================
  // length register fields
  localparam int CRBS_LEN_REMOTE_BIT   = 6;
  localparam int CRBS_DLC_W            = 4;

  // ==========================================================================
  // interrupt status bits
  localparam int CRBS_IRQ_W            = 3;
  localparam int CRBS_IRQ_B0_FULL      = 0;
  localparam int CRBS_IRQ_B0_DROP      = 1;
  localparam int CRBS_IRQ_SHARED_RX    = 2;

  // ==========================================================================
  // reset values
  localparam logic [1:0] CRBS_ACCEPT_RST   = 2'h0;
  localparam logic [7:0] CRBS_BYTE_RST     = 8'h00;
  localparam logic [CRBS_IRQ_W-1:0] CRBS_IRQ_RST = 3'h0;

  // ==========================================================================
  // operating modes and legacy acceptance codes
  typedef enum logic [1:0]
  {
    CRBS_MODE_LEGACY = 2'b00,
    CRBS_MODE_ENH1   = 2'b01,
    CRBS_MODE_ENH2   = 2'b10
  } crbs_mode_e;

  localparam logic [1:0] CRBS_ACC_ALL      = 2'b11;
  localparam logic [1:0] CRBS_ACC_EXT      = 2'b10;
  localparam logic [1:0] CRBS_ACC_STD      = 2'b01;

endpackage : crbs_pkg

// ### src/crbs_frame_if.sv
`timescale 1ns/100ps
interface crbs_frame_if;
  import crbs_pkg::*;

  logic                         valid;
  logic                         remote;
  logic                         extended;
  logic                         error;
  logic                         filter_hit;
  crbs_mode_e                   mode;
  logic [1:0]                   accept_mode;
  logic                         accept;

  modport src
  (
    output valid, remote, extended, error, filter_hit, mode, accept_mode,
    input  accept
  );
  modport acc
  (
    input  valid, remote, extended, error, filter_hit, mode, accept_mode,
    output accept
  );
endinterface : crbs_frame_if

// ### src/crbs_accept.sv
`timescale 1ns/100ps
module crbs_accept
  import crbs_pkg::*;
(
  // frame and mode
  crbs_frame_if.acc frame
);

  // ==========================================================================
  // acceptance decision
  always_comb
  begin
    frame.accept = 1'b0;
    if (frame.valid)
    begin
      if (frame.mode == CRBS_MODE_LEGACY)
      begin
        case (frame.accept_mode)
          CRBS_ACC_ALL: frame.accept = 1'b1; // R1
          CRBS_ACC_EXT: frame.accept = !frame.error && frame.filter_hit && frame.extended;
          CRBS_ACC_STD: frame.accept = !frame.error && frame.filter_hit && !frame.extended;
          default:      frame.accept = !frame.error && frame.filter_hit;
        endcase
      end
      else if (frame.accept_mode[1])
        frame.accept = 1'b1; // R10
      else
        frame.accept = !frame.error && frame.filter_hit; // R10
    end
  end

endmodule : crbs_accept

// ### src/crbs_irq.sv
`timescale 1ns/100ps
module crbs_irq
  import crbs_pkg::*;
#(
  parameter int WIDTH = CRBS_IRQ_W
)
(
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             resetn_in,
  // events and software access
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic [WIDTH-1:0] clear_in,
  input  wire logic             mask_we_in,
  input  wire logic [WIDTH-1:0] mask_wdata_in,
  // state
  output logic      [WIDTH-1:0] status_out,
  output logic      [WIDTH-1:0] mask_out,
  output logic                  irq_out
);

  logic [WIDTH-1:0] status_reg;
  logic [WIDTH-1:0] mask_reg;

  // ==========================================================================
  // sticky status: an event in the clearing cycle survives
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~clear_in) | event_in;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      mask_reg <= '0;
    else if (mask_we_in)
      mask_reg <= mask_wdata_in;
  end

  assign status_out = status_reg;
  assign mask_out   = mask_reg;
  assign irq_out    = |(status_reg & mask_reg);

endmodule : crbs_irq

// ### src/crbs_top.sv
// Summary of operation
// R1 - legacy mode, accept code 11: every frame stored, errors included, filters ignored
// R2 - control remote flag (bit 3 legacy, bit 5 enhanced) shows stored frame was remote
// R3 - enhanced modes: control bits 4..0 give the matching filter index
// R4 - legacy mode: jump-table offset bit lets both buffers share one jump table
// R5 - length register bit 6 is remote flag of received frame; bit 7 reads 0
// R6 - length register bits 5 and 4 always read 0
// R7 - length field holds received byte count; 0..8 bytes, 9 upward reserved
// R8 - length registers exist only in enhanced modes 1 and 2
// R9 - full flag set on store, buffer closed while set; irq flag reasserts while full
// R10 - enhanced modes: accept bit 1 takes all frames, 0 only valid filtered frames
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module crbs_top
  import crbs_pkg::*;
#(
  parameter int         NUM_SHARED  = 6,
  parameter logic       JUMP_OFFSET = 1'b0
)
(
  // clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         resetn_in,
  // register port
  input  wire logic [7:0]                   reg_addr_in,
  input  wire logic [7:0]                   reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [7:0]                   reg_rdata_out,
  // received frames from the protocol engine
  input  wire logic                         frame_valid_in,
  input  wire logic [2:0]                   frame_target_in,
  input  wire logic                         frame_remote_request_in,
  input  wire logic                         extended_id_flag_in,
  input  wire logic                         frame_error_in,
  input  wire logic                         filter_hit_in,
  input  wire logic [CRBS_FILTER_IDX_W-1:0] filter_match_index_in,
  input  wire logic [CRBS_DLC_W-1:0]        frame_dlc_in,
  // status
  output logic                              frame_stored_out,
  output logic                              rollover_out,
  output logic                              irq_out
);

  // ==========================================================================
  // state
  crbs_mode_e                   op_mode_reg;
  logic [1:0]                   buffer_accept_mode_reg;
  logic                         rx_buffer_full_reg;
  logic                         stored_remote_flag_reg;
  logic                         buffer0_overflow_enable_reg;
  logic [CRBS_FILTER_IDX_W-1:0] filter_match_index_reg;
  logic [NUM_SHARED-1:0]        buffer_direction_select_reg;
  logic [NUM_SHARED-1:0]        len_remote_reg;
  logic [CRBS_DLC_W-1:0]        len_dlc_reg [NUM_SHARED];
  logic [7:0]                   rdata_reg;
  logic                         stored_reg;
  logic                         rollover_reg;

  logic                         enhanced;
  logic                         accept;
  logic                         to_b0;
  logic                         b0_store;
  logic                         b0_drop;
  logic [NUM_SHARED-1:0]        sh_store;
  logic [CRBS_IRQ_W-1:0]        irq_event;
  logic [CRBS_IRQ_W-1:0]        irq_clear;
  logic [CRBS_IRQ_W-1:0]        irq_status;
  logic [CRBS_IRQ_W-1:0]        irq_mask;
  logic                         wr_ctrl;
  logic [7:0]                   ctrl_view;
  logic [7:0]                   rd_next;

  crbs_frame_if frame_if ();

  // ==========================================================================
  // acceptance
  // the decision is combinational so a frame is taken in its own cycle
  assign frame_if.valid       = frame_valid_in;
  assign frame_if.remote      = frame_remote_request_in;
  assign frame_if.extended    = extended_id_flag_in;
  assign frame_if.error       = frame_error_in;
  assign frame_if.filter_hit  = filter_hit_in;
  assign frame_if.mode        = op_mode_reg;
  assign frame_if.accept_mode = buffer_accept_mode_reg;
  assign accept               = frame_if.accept;

  crbs_accept u_accept
  (
    .frame (frame_if.acc)
  );

  assign enhanced = (op_mode_reg != CRBS_MODE_LEGACY);
  assign to_b0    = accept && (frame_target_in == 3'h0);
  // a full buffer is closed; the frame is lost or handed on
  assign b0_store = to_b0 && !rx_buffer_full_reg; // R9
  assign b0_drop  = to_b0 && rx_buffer_full_reg; // R9
  // read-only control bits ignore the write data
  assign wr_ctrl  = reg_wr_in && (reg_addr_in == CRBS_OFF_B0_CTRL);

  // ==========================================================================
  // buffer 0 control
  // the store wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rx_buffer_full_reg <= 1'b0;
    else if (b0_store)
      rx_buffer_full_reg <= 1'b1; // R9
    else if (wr_ctrl && !reg_wdata_in[CRBS_B0_FULL_BIT])
      rx_buffer_full_reg <= 1'b0; // R9
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      buffer_accept_mode_reg <= CRBS_ACCEPT_RST;
    else if (wr_ctrl)
    begin
      buffer_accept_mode_reg[1] <= reg_wdata_in[CRBS_B0_MODE_HI_BIT]; // R10
      // bit 5 is the remote flag in enhanced modes, so the low bit is frozen there
      if (!enhanced)
        buffer_accept_mode_reg[0] <= reg_wdata_in[CRBS_B0_MODE_LO_BIT]; // R1
    end
  end

  // legacy-only bit; enhanced modes keep its last value
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      buffer0_overflow_enable_reg <= 1'b0;
    else if (wr_ctrl && !enhanced)
      buffer0_overflow_enable_reg <= reg_wdata_in[CRBS_B0_OVF_EN_BIT];
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      stored_remote_flag_reg <= 1'b0;
    else if (b0_store)
      stored_remote_flag_reg <= frame_remote_request_in; // R2
  end

  // all five bits kept in legacy mode too; that view shows only bit 0
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      filter_match_index_reg <= '0;
    else if (b0_store)
      filter_match_index_reg <= filter_match_index_in; // R3
  end

  // ==========================================================================
  // operating mode and direction select
  // the unused mode code is ignored so the block never leaves a defined mode
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      op_mode_reg <= CRBS_MODE_LEGACY;
    else if (reg_wr_in && (reg_addr_in == CRBS_OFF_OP_MODE))
    begin
      case (reg_wdata_in[1:0])
        CRBS_MODE_LEGACY: op_mode_reg <= CRBS_MODE_LEGACY;
        CRBS_MODE_ENH1:   op_mode_reg <= CRBS_MODE_ENH1;
        CRBS_MODE_ENH2:   op_mode_reg <= CRBS_MODE_ENH2;
        default:          op_mode_reg <= op_mode_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      buffer_direction_select_reg <= '0;
    else if (reg_wr_in && (reg_addr_in == CRBS_OFF_DIR_SEL))
      buffer_direction_select_reg <= reg_wdata_in[NUM_SHARED-1:0];
  end

  // ==========================================================================
  // shared buffers in receive mode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SHARED; gi++)
    begin : g_shared
      assign sh_store[gi] = accept && enhanced && !buffer_direction_select_reg[gi]
                            && (frame_target_in == 3'(gi + 1)); // R8

      // reserved length codes are kept as received, software sees the raw code
      always_ff @(posedge ref_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          len_remote_reg[gi] <= 1'b0;
          len_dlc_reg[gi]    <= '0;
        end
        else if (sh_store[gi])
        begin
          len_remote_reg[gi] <= frame_remote_request_in; // R5
          len_dlc_reg[gi]    <= frame_dlc_in; // R7
        end
      end
    end
  endgenerate

  // ==========================================================================
  // interrupts
  // the full event is a level, so clearing only the flag brings it back
  assign irq_event[CRBS_IRQ_B0_FULL]   = rx_buffer_full_reg || b0_store; // R9
  assign irq_event[CRBS_IRQ_B0_DROP]   = b0_drop && !buffer0_overflow_enable_reg;
  assign irq_event[CRBS_IRQ_SHARED_RX] = |sh_store;
  assign irq_clear = (reg_wr_in && (reg_addr_in == CRBS_OFF_IRQ_STAT))
                     ? reg_wdata_in[CRBS_IRQ_W-1:0] : '0;

  crbs_irq #(
    .WIDTH (CRBS_IRQ_W)
  ) u_irq (
    .ref_clk_in    (ref_clk_in),
    .resetn_in     (resetn_in),
    .event_in      (irq_event),
    .clear_in      (irq_clear),
    .mask_we_in    (reg_wr_in && (reg_addr_in == CRBS_OFF_IRQ_MASK)),
    .mask_wdata_in (reg_wdata_in[CRBS_IRQ_W-1:0]),
    .status_out    (irq_status),
    .mask_out      (irq_mask),
    .irq_out       (irq_out)
  );

  // ==========================================================================
  // register read
  // data stand one cycle only, so a stale byte is never taken twice
  always_comb
  begin
    ctrl_view = CRBS_BYTE_RST;
    ctrl_view[CRBS_B0_FULL_BIT]    = rx_buffer_full_reg;
    ctrl_view[CRBS_B0_MODE_HI_BIT] = buffer_accept_mode_reg[1];
    if (enhanced)
    begin
      ctrl_view[CRBS_B0_REM_ENH_BIT]         = stored_remote_flag_reg; // R2
      ctrl_view[CRBS_FILTER_IDX_W-1:0]       = filter_match_index_reg; // R3
    end
    else
    begin
      ctrl_view[CRBS_B0_MODE_LO_BIT]  = buffer_accept_mode_reg[0];
      ctrl_view[CRBS_B0_REM_LEG_BIT]  = stored_remote_flag_reg; // R2
      ctrl_view[CRBS_B0_OVF_EN_BIT]   = buffer0_overflow_enable_reg;
      // fixed offset so both buffers share one jump table
      ctrl_view[CRBS_B0_JUMP_TABLE_OFFSET_BIT]    = JUMP_OFFSET; // R4
      ctrl_view[0]                    = filter_match_index_reg[0];
    end
  end

  always_comb
  begin
    rd_next = CRBS_BYTE_RST;
    case (reg_addr_in)
      CRBS_OFF_B0_CTRL:  rd_next = ctrl_view;
      CRBS_OFF_OP_MODE:  rd_next = {6'h00, op_mode_reg};
      CRBS_OFF_DIR_SEL:  rd_next[NUM_SHARED-1:0] = buffer_direction_select_reg;
      CRBS_OFF_IRQ_STAT: rd_next[CRBS_IRQ_W-1:0] = irq_status;
      CRBS_OFF_IRQ_MASK: rd_next[CRBS_IRQ_W-1:0] = irq_mask;
      default:
      begin
        for (int i = 0; i < NUM_SHARED; i++)
        begin
          // bits 7, 5 and 4 stay zero; a transmit-mode buffer reads zero here
          if (enhanced && !buffer_direction_select_reg[i]
              && (reg_addr_in == CRBS_OFF_LEN_BASE + 8'(i))) // R8
          begin
            rd_next[CRBS_LEN_REMOTE_BIT] = len_remote_reg[i]; // R5
            rd_next[CRBS_DLC_W-1:0]      = len_dlc_reg[i]; // R6 R7
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_reg <= CRBS_BYTE_RST;
    else
      rdata_reg <= reg_rd_in ? rd_next : CRBS_BYTE_RST;
  end

  // ==========================================================================
  // event pulses
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      stored_reg <= 1'b0;
    else
      stored_reg <= b0_store || (|sh_store);
  end

  // a rolled frame is reported here instead of in the drop status bit
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rollover_reg <= 1'b0;
    else
      rollover_reg <= b0_drop && buffer0_overflow_enable_reg; // R9
  end

  assign reg_rdata_out    = rdata_reg;
  assign frame_stored_out = stored_reg;
  assign rollover_out     = rollover_reg;

endmodule : crbs_top

// ### sim/crbs_top_checker.sv
`timescale 1ns/100ps
module crbs_checker
  import crbs_pkg::*;
#(
  parameter int   NUM_SHARED  = 6,
  parameter logic JUMP_OFFSET = 1'b0
)
(
  // clock and reset
  input wire logic                         ref_clk_in,
  input wire logic                         resetn_in,
  // register port
  input wire logic [7:0]                   reg_addr_in,
  input wire logic [7:0]                   reg_wdata_in,
  input wire logic                         reg_wr_in,
  input wire logic                         reg_rd_in,
  input wire logic [7:0]                   reg_rdata_out,
  // received frames
  input wire logic                         frame_valid_in,
  input wire logic [2:0]                   frame_target_in,
  input wire logic                         frame_remote_request_in,
  input wire logic                         extended_id_flag_in,
  input wire logic                         frame_error_in,
  input wire logic                         filter_hit_in,
  input wire logic [CRBS_FILTER_IDX_W-1:0] filter_match_index_in,
  input wire logic [CRBS_DLC_W-1:0]        frame_dlc_in,
  // status
  input wire logic                         frame_stored_out,
  input wire logic                         rollover_out,
  input wire logic                         irq_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // ==========================================================================
  // register port
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside the answer cycle");
  unmapped_zero_a: assert property
    ($past(reg_rd_in && reg_addr_in inside {[8'h05:8'h0F]}) |-> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  len_reserved_a: assert property
    ($past(reg_rd_in && reg_addr_in[7:4] == 4'h1) |-> !reg_rdata_out[7] && reg_rdata_out[5:4] == 2'b00)
    else $error("length register reserved bits set");

  // ==========================================================================
  // interrupt line
  mask_zero_a: assert property
    (reg_wr_in && reg_addr_in == CRBS_OFF_IRQ_MASK && reg_wdata_in[2:0] == 3'h0 |=> !irq_out)
    else $error("irq high with all sources masked");
  irq_rise_a: assert property ($rose(irq_out) |-> $past(frame_valid_in || reg_wr_in))
    else $error("irq rose without a cause");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(reg_wr_in))
    else $error("irq fell without software write");

  // ==========================================================================
  // frame port
  stored_cause_a: assert property (frame_stored_out |-> $past(frame_valid_in))
    else $error("stored pulse without a frame");
  rollover_cause_a: assert property
    (rollover_out |-> $past(frame_valid_in && frame_target_in == 3'd0))
    else $error("rollover without a buffer 0 frame");
  rollover_excl_a: assert property (rollover_out |-> !frame_stored_out)
    else $error("rolled frame also reported stored");

  stored_c: cover property (frame_stored_out);
  rollover_c: cover property (rollover_out);
  irq_clear_c: cover property ($fell(irq_out));
endmodule : crbs_checker

bind crbs_top crbs_checker #(.NUM_SHARED(NUM_SHARED), .JUMP_OFFSET(JUMP_OFFSET)) i_crbs_checker
(
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .frame_valid_in(frame_valid_in), .frame_target_in(frame_target_in),
  .frame_remote_request_in(frame_remote_request_in), .extended_id_flag_in(extended_id_flag_in),
  .frame_error_in(frame_error_in), .filter_hit_in(filter_hit_in),
  .filter_match_index_in(filter_match_index_in), .frame_dlc_in(frame_dlc_in),
  .frame_stored_out(frame_stored_out), .rollover_out(rollover_out), .irq_out(irq_out)
);

// ### sim/crbs_can_node.sv
`timescale 1ns/100ps
module crbs_can_node
  import crbs_pkg::*;
(
  // clock
  input  wire logic                    ref_clk_in,
  // frame as handed over by the bus side
  output logic                         frame_valid_out,
  output logic [2:0]                   frame_target_out,
  output logic                         frame_remote_out,
  output logic                         frame_ext_out,
  output logic                         frame_error_out,
  output logic                         filter_hit_out,
  output logic [CRBS_FILTER_IDX_W-1:0] filter_index_out,
  output logic [CRBS_DLC_W-1:0]        frame_dlc_out
);
  logic [15:0] fields_reg;

  assign {frame_target_out, frame_remote_out, frame_ext_out, frame_error_out, filter_hit_out,
          filter_index_out, frame_dlc_out} = fields_reg;

  initial
  begin
    frame_valid_out = 1'b0;
    fields_reg      = 16'h0000;
  end

  // ==========================================================================
  // one frame per call; fields turn to junk outside the frame cycle so a
  // design that samples them late cannot pass by luck
  task send(input logic [15:0] f, input int gap);
    repeat (gap) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    frame_valid_out <= 1'b1;
    fields_reg      <= f;
    @(posedge ref_clk_in);
    frame_valid_out <= 1'b0;
    fields_reg      <= ~f;
  endtask : send
endmodule : crbs_can_node

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import crbs_pkg::*;

  logic                         ref_clk_in = 1'b0;
  logic                         resetn_in;
  logic [7:0]                   reg_addr_in = 8'h00;
  logic [7:0]                   reg_wdata_in = 8'h00;
  logic                         reg_wr_in = 1'b0;
  logic                         reg_rd_in = 1'b0;
  logic [7:0]                   reg_rdata_out;
  logic                         fv, fr_rem, fr_ext, fr_err, fr_hit, stored, roll, irq;
  logic [2:0]                   fr_tgt;
  logic [CRBS_FILTER_IDX_W-1:0] fr_idx;
  logic [CRBS_DLC_W-1:0]        fr_dlc;
  int                           bad_count = 0;
  int                           n_compared = 0;

  always #50 ref_clk_in = ~ref_clk_in;

  // jump offset tied high so the legacy view shows a non-reset value
  crbs_top #(.NUM_SHARED(6), .JUMP_OFFSET(1'b1)) i_crbs_top
  (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .frame_valid_in(fv), .frame_target_in(fr_tgt),
    .frame_remote_request_in(fr_rem), .extended_id_flag_in(fr_ext), .frame_error_in(fr_err),
    .filter_hit_in(fr_hit), .filter_match_index_in(fr_idx), .frame_dlc_in(fr_dlc),
    .frame_stored_out(stored), .rollover_out(roll), .irq_out(irq)
  );

  crbs_can_node i_crbs_can_node
  (
    .ref_clk_in(ref_clk_in), .frame_valid_out(fv), .frame_target_out(fr_tgt),
    .frame_remote_out(fr_rem), .frame_ext_out(fr_ext), .frame_error_out(fr_err),
    .filter_hit_out(fr_hit), .filter_index_out(fr_idx), .frame_dlc_out(fr_dlc)
  );

  // ==========================================================================
  // tasks
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp, "read");
  endtask : rd

  function automatic logic [15:0] fr(input logic [2:0] t, input logic r, x, e, h,
                                     input logic [4:0] i, input logic [3:0] d);
    return {t, r, x, e, h, i, d};
  endfunction : fr

  task fs(input logic [15:0] f, input logic exp_st, input logic exp_ro);
    i_crbs_can_node.send(f, 1);
    #1;
    chk({7'h00, stored}, {7'h00, exp_st}, "stored pulse");
    chk({7'h00, roll}, {7'h00, exp_ro}, "rollover pulse");
  endtask : fs

  task done(input string s);
    $display("test %s done", s);
  endtask : done

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // sequence
  initial
  begin
    resetn_in = 1'b0;
    repeat (16) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    rd(CRBS_OFF_B0_CTRL, 8'h02);
    rd(CRBS_OFF_IRQ_STAT, 8'h00);
    rd(8'h07, 8'h00);
    done("reset");
    wr(CRBS_OFF_IRQ_MASK, 8'h07);
    fs(fr(3'd0, 1'b1, 1'b0, 1'b0, 1'b1, 5'h01, 4'h3), 1'b1, 1'b0);
    chk({7'h00, irq}, 8'h01, "irq");
    fs(fr(3'd0, 1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 4'h1), 1'b0, 1'b0);
    rd(CRBS_OFF_B0_CTRL, 8'h8B);
    rd(CRBS_OFF_IRQ_STAT, 8'h03);
    wr(CRBS_OFF_IRQ_MASK, 8'h00);
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(CRBS_OFF_IRQ_MASK, 8'h07);
    wr(CRBS_OFF_IRQ_STAT, 8'h03);
    rd(CRBS_OFF_IRQ_STAT, 8'h01);
    wr(CRBS_OFF_B0_CTRL, 8'h00);
    rd(CRBS_OFF_B0_CTRL, 8'h0B);
    wr(CRBS_OFF_IRQ_STAT, 8'h01);
    chk({7'h00, irq}, 8'h00, "irq cleared");
    done("legacy store");
    for (int c = 0; c < 4; c++)
    begin
      wr(CRBS_OFF_B0_CTRL, {1'b0, c[1:0], 5'h00});
      fs(fr(3'd0, 1'b0, 1'b1, 1'b0, 1'b1, 5'h00, 4'h0), c != 1, 1'b0);
      wr(CRBS_OFF_B0_CTRL, {1'b0, c[1:0], 5'h00});
      fs(fr(3'd0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00, 4'h0), c == 3, 1'b0);
    end
    done("legacy accept codes");
    wr(CRBS_OFF_B0_CTRL, 8'h04);
    wr(CRBS_OFF_IRQ_STAT, 8'h07);
    fs(fr(3'd0, 1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 4'h0), 1'b1, 1'b0);
    fs(fr(3'd0, 1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 4'h0), 1'b0, 1'b1);
    rd(CRBS_OFF_IRQ_STAT, 8'h01);
    fs(fr(3'd1, 1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 4'h2), 1'b0, 1'b0);
    rd(CRBS_OFF_LEN_BASE, 8'h00);
    done("rollover");
    wr(CRBS_OFF_OP_MODE, 8'h01);
    wr(CRBS_OFF_B0_CTRL, 8'h00);
    fs(fr(3'd0, 1'b1, 1'b0, 1'b0, 1'b1, 5'h15, 4'h2), 1'b1, 1'b0);
    rd(CRBS_OFF_B0_CTRL, 8'hB5);
    wr(CRBS_OFF_B0_CTRL, 8'h00);
    fs(fr(3'd0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h02, 4'h0), 1'b0, 1'b0);
    wr(CRBS_OFF_B0_CTRL, 8'h40);
    fs(fr(3'd0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h02, 4'h0), 1'b1, 1'b0);
    rd(CRBS_OFF_B0_CTRL, 8'hC2);
    done("enhanced control");
    wr(CRBS_OFF_DIR_SEL, 8'h00);
    for (int n = 0; n < 6; n++)
    begin
      fs(fr(3'(n + 1), n[0], 1'b0, 1'b0, 1'b1, 5'h00, 4'(2 * n + 4)), 1'b1, 1'b0);
      rd(8'(CRBS_OFF_LEN_BASE + n), {1'b0, n[0], 2'b00, 4'(2 * n + 4)});
    end
    wr(CRBS_OFF_DIR_SEL, 8'h01);
    fs(fr(3'd1, 1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 4'h1), 1'b0, 1'b0);
    rd(CRBS_OFF_LEN_BASE, 8'h00);
    rd(CRBS_OFF_IRQ_STAT, 8'h05);
    wr(CRBS_OFF_OP_MODE, 8'h02);
    rd(8'h11, 8'h46);
    wr(CRBS_OFF_OP_MODE, 8'h03);
    rd(CRBS_OFF_OP_MODE, 8'h02);
    wr(CRBS_OFF_OP_MODE, 8'h00);
    rd(8'h11, 8'h00);
    done("length registers");
    complete_run();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    $display("FAIL at %0t: run did not finish", $time);
    complete_run();
  end
endmodule : tb_top
